/* File: src/fds_cmd.sv */
// fifo sizing and ram synthesis command interpreter with apb register access
// assumes apb master on pclk; command words queue in a fifo before decoding
// Summary of operation
// - code 0x0003 starts fifo sizing; next word bits [2:0] select size
// - after reset the whole 1024-word ram is fifo, selection zero
// - fifo ends at 0x3ff; begins 0x000/0x200/0x300/0x380/0x3c0 for selections 0..4
// - ram below the fifo region is kept out of fifo use
// - code 0x0012 starts ram synthesis, followed by one parameter word
// - parameter word: last wave in top nibble, first wave in next nibble
// - low five bits: relative offset, stop, next wave, next slice, repeat
// - source value 3 is table synthesis, value 2 stored playback
// - commands arrive as code word then parameter words to the entry register
`timescale 1ns/1ps
module fds_cmd
    import fds_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              pce,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [FDS_AW-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic [1:0]             playback_source_select,
    output logic                   drive_enable,
    output logic [2:0]             fifo_size_sel,
    output logic [9:0]             fifo_begin_addr,
    output logic [9:0]             fifo_end_addr,
    input  wire logic [9:0]        probe_addr,
    output logic                   probe_in_fifo,
    output logic                   synth_valid,
    input  wire logic              synth_ready,
    output logic [3:0]             synth_end_wave,
    output logic [3:0]             synth_start_wave,
    output logic                   relative_offset_flag,
    output logic                   stop_flag,
    output logic                   advance_wave_flag,
    output logic                   advance_slice_flag,
    output logic                   repeat_flag
);
    typedef struct packed {
        fds_state_t        st;
        logic [2:0]        sel;
        logic [9:0]        base;
        logic [1:0]        src;
        logic              drive;
        logic [15:0]       synth_word;
        logic              synth_v;
        logic              seq_err;
        logic              unk_err;
        logic              probe_hit;
        logic [31:0]       rdata;
    } fds_cmd_st_t;

    fds_cmd_st_t                r;
    fds_cmd_st_t                n;
    logic                       setup;
    logic                       access;
    logic                       hit_cmd;
    logic                       hit_ctrl;
    logic                       hit_status;
    logic                       hit_synth;
    logic                       mapped;
    logic                       push_valid;
    logic                       push_ready;
    logic                       word_valid;
    logic                       word_ready;
    logic [FDS_WORD_W-1:0]      word;
    logic                       pop;
    logic                       wr_ctrl;
    logic                       wr_status;
    logic                       src_ok;
    logic [9:0]                 base_lut;
    logic [31:0]                status_word;

    assign setup      = psel & ~penable;
    assign access     = psel & penable;
    assign hit_cmd    = (paddr == FDS_REG_CMD);
    assign hit_ctrl   = (paddr == FDS_REG_CTRL);
    assign hit_status = (paddr == FDS_REG_STATUS);
    assign hit_synth  = (paddr == FDS_REG_SYNTH);
    assign mapped     = hit_cmd | hit_ctrl | hit_status | hit_synth;

    // each write to the entry register queues one command word, in order
    assign push_valid = access & pwrite & hit_cmd;
    // a full queue stretches the access phase instead of dropping a word
    assign pready     = push_valid ? push_ready : 1'b1;
    assign pslverr    = access & ~mapped;
    assign prdata     = r.rdata;
    assign wr_ctrl    = access & pwrite & hit_ctrl & pstrb[0];
    assign wr_status  = access & pwrite & hit_status & pstrb[2];

    fds_fifo #(
        .W (FDS_WORD_W),
        .D (FDS_FIFO_D)
    ) u_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .ce        (pce),
        .in_valid  (push_valid),
        .in_ready  (push_ready),
        .in_data   (pwdata[FDS_WORD_W-1:0]),
        .out_valid (word_valid),
        .out_ready (word_ready),
        .out_data  (word)
    );

    // decoding stalls while a synthesis request waits for the engine
    assign word_ready = (r.st != FDS_SYNTH_OUT);
    assign pop        = word_valid & word_ready;

    // sizing is only legal with a ram based source and the drive off
    assign src_ok = ((r.src == FDS_SRC_RAM_PLAY) | (r.src == FDS_SRC_TBL_SYNTH)) & ~r.drive;

    // region start per selection; the top address is fixed
    always_comb begin
        case (word[FDS_SEL_MSB:FDS_SEL_LSB])
            3'h0:    base_lut = FDS_BASE_SEL0;
            3'h1:    base_lut = FDS_BASE_SEL1;
            3'h2:    base_lut = FDS_BASE_SEL2;
            3'h3:    base_lut = FDS_BASE_SEL3;
            3'h4:    base_lut = FDS_BASE_SEL4;
            default: base_lut = r.base;
        endcase
    end

    always_comb begin
        status_word = '0;
        status_word[FDS_ST_SEL_LSB +: 3]   = r.sel;
        status_word[FDS_ST_BASE_LSB +: 10] = r.base;
        status_word[FDS_ST_SEQERR]         = r.seq_err;
        status_word[FDS_ST_UNKERR]         = r.unk_err;
        status_word[FDS_ST_BUSY]           = word_valid | (r.st != FDS_IDLE);
    end

    always_comb begin
        n = r;
        // read data is caught in the setup phase so it is a flop in the access phase
        if (setup && !pwrite) begin
            n.rdata = '0;
            if (hit_ctrl) begin
                n.rdata[FDS_CTRL_SRC_MSB:FDS_CTRL_SRC_LSB] = r.src;
                n.rdata[FDS_CTRL_DRIVE]                    = r.drive;
            end else if (hit_status) begin
                n.rdata = status_word;
            end else if (hit_synth) begin
                n.rdata[FDS_WORD_W-1:0] = r.synth_word;
            end
        end
        if (wr_ctrl) begin
            n.src   = pwdata[FDS_CTRL_SRC_MSB:FDS_CTRL_SRC_LSB];
            n.drive = pwdata[FDS_CTRL_DRIVE];
        end
        // write one to clear; a new error in the same cycle is set below and wins
        if (wr_status) begin
            if (pwdata[FDS_ST_SEQERR]) begin
                n.seq_err = 1'b0;
            end
            if (pwdata[FDS_ST_UNKERR]) begin
                n.unk_err = 1'b0;
            end
        end
        case (r.st)
            FDS_IDLE: begin
                if (pop) begin
                    if (word == FDS_CMD_DEPTH) begin
                        n.st = FDS_DEPTH_ARG;
                    end else if (word == FDS_CMD_SYNTH) begin
                        n.st = FDS_SYNTH_ARG;
                    end else begin
                        n.unk_err = 1'b1;
                    end
                end
            end
            FDS_DEPTH_ARG: begin
                if (pop) begin
                    n.st = FDS_IDLE;
                    // out of range selections leave the region as it was
                    if (word[FDS_SEL_MSB:FDS_SEL_LSB] <= FDS_SEL_MAX) begin
                        n.sel  = word[FDS_SEL_MSB:FDS_SEL_LSB];
                        n.base = base_lut;
                    end
                    // the region is still applied; software sees the misuse in status
                    if (!src_ok) begin
                        n.seq_err = 1'b1;
                    end
                end
            end
            FDS_SYNTH_ARG: begin
                if (pop) begin
                    n.synth_word = word;
                    n.synth_v    = 1'b1;
                    n.st         = FDS_SYNTH_OUT;
                end
            end
            FDS_SYNTH_OUT: begin
                if (synth_ready) begin
                    n.synth_v = 1'b0;
                    n.st      = FDS_IDLE;
                end
            end
            default: begin
                n.st = FDS_IDLE;
            end
        endcase
        // fifo spans base up to the top word; everything lower is kept out
        n.probe_hit = (probe_addr >= r.base);
    end

    // zero reset gives selection 0 and base 0x000: the full ram is fifo
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            r <= '0;
        end else if (pce) begin
            r <= n;
        end
    end

    assign playback_source_select = r.src;
    assign drive_enable           = r.drive;
    assign fifo_size_sel          = r.sel;
    assign fifo_begin_addr        = r.base;
    assign fifo_end_addr          = FDS_RAM_LAST;
    assign probe_in_fifo          = r.probe_hit;
    assign synth_valid            = r.synth_v;
    assign synth_end_wave         = r.synth_word[FDS_END_MSB:FDS_END_LSB];
    assign synth_start_wave       = r.synth_word[FDS_START_MSB:FDS_START_LSB];
    assign relative_offset_flag   = r.synth_word[FDS_OFFSET_BIT];
    assign stop_flag              = r.synth_word[FDS_STOP_BIT];
    assign advance_wave_flag      = r.synth_word[FDS_NXTWAVE_BIT];
    assign advance_slice_flag     = r.synth_word[FDS_NXTSLICE_BIT];
    assign repeat_flag            = r.synth_word[FDS_REPEAT_BIT];

    depth_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_IDLE && pop && word == FDS_CMD_DEPTH |=> r.st == FDS_DEPTH_ARG)
        else $error("sizing code not decoded");

    synth_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_IDLE && pop && word == FDS_CMD_SYNTH |=> r.st == FDS_SYNTH_ARG)
        else $error("synthesis code not decoded");

    base_table_a: assert property (@(posedge pclk) disable iff (!presetn)
        (r.sel == 3'h0 && r.base == FDS_BASE_SEL0) || (r.sel == 3'h1 && r.base == FDS_BASE_SEL1)
        || (r.sel == 3'h2 && r.base == FDS_BASE_SEL2) || (r.sel == 3'h3 && r.base == FDS_BASE_SEL3)
        || (r.sel == 3'h4 && r.base == FDS_BASE_SEL4))
        else $error("fifo begin address does not match selection");

    size_apply_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_DEPTH_ARG && pop && word[FDS_SEL_MSB:FDS_SEL_LSB] <= FDS_SEL_MAX
        |=> fifo_size_sel == $past(word[FDS_SEL_MSB:FDS_SEL_LSB]))
        else $error("size selection not applied");

    bad_size_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_DEPTH_ARG && pop && word[FDS_SEL_MSB:FDS_SEL_LSB] > FDS_SEL_MAX
        |=> $stable(fifo_size_sel) && $stable(fifo_begin_addr))
        else $error("illegal size selection changed the region");

    synth_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_SYNTH_ARG && pop |=> synth_valid
        && synth_end_wave == $past(word[FDS_END_MSB:FDS_END_LSB])
        && synth_start_wave == $past(word[FDS_START_MSB:FDS_START_LSB])
        && repeat_flag == $past(word[FDS_REPEAT_BIT]))
        else $error("synthesis fields wrong");

    synth_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        synth_valid && !synth_ready |=> synth_valid && $stable(stop_flag)
        && $stable(relative_offset_flag))
        else $error("synthesis request dropped before taken");

    probe_region_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce |=> probe_in_fifo == ($past(probe_addr) >= $past(r.base)))
        else $error("region membership wrong");

    full_stall_a: assert property (@(posedge pclk) disable iff (!presetn)
        push_valid && !push_ready |-> !pready)
        else $error("entry write completed while queue full");

    seq_check_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_DEPTH_ARG && pop && r.drive |=> r.seq_err)
        else $error("sizing with drive on not flagged");

    unk_code_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_IDLE && pop && word != FDS_CMD_DEPTH && word != FDS_CMD_SYNTH
        |=> r.unk_err)
        else $error("unknown command word not flagged");

    synth_release_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && synth_valid && synth_ready |=> !synth_valid)
        else $error("synthesis request not released");

    src_write_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && wr_ctrl
        |=> playback_source_select == $past(pwdata[FDS_CTRL_SRC_MSB:FDS_CTRL_SRC_LSB]))
        else $error("source select write not applied");

    flag_fields_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && r.st == FDS_SYNTH_ARG && pop
        |=> {relative_offset_flag, stop_flag, advance_wave_flag, advance_slice_flag, repeat_flag}
        == $past(word[FDS_OFFSET_BIT:FDS_REPEAT_BIT]))
        else $error("synthesis control flags wrong");

    // a clear racing a new misuse must lose, so the clear is only checked without one
    seq_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        pce && wr_status && pwdata[FDS_ST_SEQERR] && !(r.st == FDS_DEPTH_ARG && pop)
        |=> !r.seq_err)
        else $error("sequence error not cleared");
endmodule

/* File: src/fds_fifo.sv */
// command word fifo with a registered head word
// assumes one clock, synchronous inputs, and a drain side that may stall
`timescale 1ns/1ps
module fds_fifo
    import fds_pkg::*;
#(
    parameter int W = 16,
    parameter int D = 16
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         ce,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(D);
    localparam logic [AW:0] DEPTH = (AW+1)'(D);

    typedef struct packed {
        logic [D-1:0][W-1:0] mem;
        logic [AW-1:0]       wp;
        logic [AW-1:0]       rp;
        logic [AW:0]         cnt;
        logic [W-1:0]        head;
        logic                head_v;
    } fds_fifo_st_t;

    fds_fifo_st_t r, n;
    logic         push;
    logic         load;

    // full is judged on the memory alone; a pop in the same cycle does not free room early
    assign in_ready  = (r.cnt != DEPTH);
    assign push      = in_valid & in_ready;
    assign load      = (r.cnt != '0) & (~r.head_v | out_ready);
    assign out_valid = r.head_v;
    assign out_data  = r.head;

    always_comb begin
        n = r;
        if (push) begin
            n.mem[r.wp] = in_data;
            n.wp        = r.wp + 1'b1;
        end
        if (load) begin
            n.head   = r.mem[r.rp];
            n.rp     = r.rp + 1'b1;
            n.head_v = 1'b1;
        end else if (out_ready) begin
            n.head_v = 1'b0;
        end
        n.cnt = r.cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, load};
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else if (ce) begin
            r <= n;
        end
    end

    fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
        r.cnt <= DEPTH)
        else $error("fifo count above depth");

    head_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
        ce && out_valid && !out_ready |=> out_valid && $stable(out_data))
        else $error("fifo head lost before it was taken");
endmodule

/* File: src/fds_pkg.sv */
// package for the fifo sizing and synthesis command interpreter
// assumes 16-bit command words arriving over a 32-bit apb slave, low half used
package fds_pkg;
    // command codes seen in the first word of a command
    localparam logic [15:0] FDS_CMD_DEPTH     = 16'h0003;
    localparam logic [15:0] FDS_CMD_SYNTH     = 16'h0012;

    // fifo sizing argument word
    localparam int          FDS_SEL_MSB       = 2;
    localparam int          FDS_SEL_LSB       = 0;
    localparam logic [2:0]  FDS_SEL_DEFAULT   = 3'h0;
    localparam logic [2:0]  FDS_SEL_MAX       = 3'h4;

    // waveform ram geometry, fifo region always ends at the top word
    localparam int          FDS_RAM_AW        = 10;
    localparam logic [9:0]  FDS_RAM_LAST      = 10'h3ff;
    localparam logic [9:0]  FDS_BASE_SEL0     = 10'h000;
    localparam logic [9:0]  FDS_BASE_SEL1     = 10'h200;
    localparam logic [9:0]  FDS_BASE_SEL2     = 10'h300;
    localparam logic [9:0]  FDS_BASE_SEL3     = 10'h380;
    localparam logic [9:0]  FDS_BASE_SEL4     = 10'h3c0;

    // synthesis argument word
    localparam int          FDS_END_MSB       = 15;
    localparam int          FDS_END_LSB       = 12;
    localparam int          FDS_START_MSB     = 11;
    localparam int          FDS_START_LSB     = 8;
    localparam int          FDS_OFFSET_BIT    = 4;
    localparam int          FDS_STOP_BIT      = 3;
    localparam int          FDS_NXTWAVE_BIT   = 2;
    localparam int          FDS_NXTSLICE_BIT  = 1;
    localparam int          FDS_REPEAT_BIT    = 0;

    // playback source codes
    localparam logic [1:0]  FDS_SRC_RAM_PLAY  = 2'h2;
    localparam logic [1:0]  FDS_SRC_TBL_SYNTH = 2'h3;

    // register byte offsets
    localparam int          FDS_AW            = 12;
    localparam logic [11:0] FDS_REG_CMD       = 12'h000;
    localparam logic [11:0] FDS_REG_CTRL      = 12'h004;
    localparam logic [11:0] FDS_REG_STATUS    = 12'h008;
    localparam logic [11:0] FDS_REG_SYNTH     = 12'h00c;

    // control register fields
    localparam int          FDS_CTRL_SRC_MSB  = 1;
    localparam int          FDS_CTRL_SRC_LSB  = 0;
    localparam int          FDS_CTRL_DRIVE    = 2;

    // status register fields
    localparam int          FDS_ST_SEL_LSB    = 0;
    localparam int          FDS_ST_BASE_LSB   = 4;
    localparam int          FDS_ST_SEQERR     = 16;
    localparam int          FDS_ST_UNKERR     = 17;
    localparam int          FDS_ST_BUSY       = 18;

    // command word fifo
    localparam int          FDS_WORD_W        = 16;
    localparam int          FDS_FIFO_D        = 16;

    typedef enum logic [1:0] {
        FDS_IDLE,
        FDS_DEPTH_ARG,
        FDS_SYNTH_ARG,
        FDS_SYNTH_OUT
    } fds_state_t;
endpackage

/* File: tb/fds_engine_model.sv */
// synthesis engine model on the far side of the synth_valid/synth_ready handshake
// assumes pclk domain; hold stalls it to back up the command queue
`timescale 1ns/1ps
module fds_engine_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        hold,
    input  wire logic        synth_valid,
    input  wire logic [3:0]  end_wave,
    input  wire logic [3:0]  start_wave,
    input  wire logic [4:0]  flags,
    output logic             synth_ready,
    output logic [7:0]       n_done,
    output logic [15:0]      last_word
);
    // one-cycle ready pulses: valid falls the edge after ready, so no double take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            synth_ready <= 1'b0;
            n_done      <= 8'h00;
            last_word   <= 16'h0000;
        end else begin
            synth_ready <= synth_valid & ~hold & ~synth_ready;
            if (synth_valid && synth_ready) begin
                n_done    <= n_done + 8'h01;
                last_word <= {end_wave, start_wave, 3'h0, flags};
            end
        end
    end
endmodule

/* File: tb/testbench.sv */
// self-checking bench for the command interpreter, apb master plus engine model
// assumes byte strobes stay all ones; the pce input runs free except where misuse_case freezes it
`timescale 1ns/1ps
module testbench;
    import fds_pkg::*;
    logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic        ce = 1, hold = 0, stalled = 0, err, pready, pslverr, sv, sr, pin, dv;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic [9:0]  probe_addr = 10'h000, fb, fe, bx;
    logic [2:0]  fs, sx;
    logic [1:0]  src;
    logic [3:0]  ew, sw;
    wire  [4:0]  fl;
    logic [7:0]  n_done, base;
    logic [15:0] last_word;
    int          n_mismatch = 0, total_checks = 0;

    always #2.5 pclk = ~pclk;

    fds_cmd i_dut (.pclk(pclk), .presetn(presetn), .pce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .playback_source_select(src), .drive_enable(dv),
        .fifo_size_sel(fs), .fifo_begin_addr(fb), .fifo_end_addr(fe), .probe_addr(probe_addr),
        .probe_in_fifo(pin), .synth_valid(sv), .synth_ready(sr), .synth_end_wave(ew),
        .synth_start_wave(sw), .relative_offset_flag(fl[4]), .stop_flag(fl[3]),
        .advance_wave_flag(fl[2]), .advance_slice_flag(fl[1]), .repeat_flag(fl[0]));

    fds_engine_model i_eng (.pclk(pclk), .presetn(presetn), .hold(hold), .synth_valid(sv),
        .end_wave(ew), .start_wave(sw), .flags(fl), .synth_ready(sr), .n_done(n_done),
        .last_word(last_word));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one apb transfer; pready is judged settled at the falling edge before the taking edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        forever begin
            @(negedge pclk);
            if (pready === 1'b1) break;
            stalled = 1'b1;
            @(posedge pclk);
        end
        rd = prdata;
        err = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic probe(input logic [9:0] a, input logic exp);
        @(posedge pclk);
        probe_addr <= a;
        @(posedge pclk);
        @(negedge pclk);
        chk("probe_in_fifo", {31'h0, exp}, {31'h0, pin});
    endtask

    task automatic reset_case;
        @(negedge pclk);
        chk("size_sel", 32'h0, {29'h0, fs});
        chk("begin", 32'h0, {22'h0, fb});
        apb(1'b0, FDS_REG_CTRL, 32'h0);
        chk("ctrl", 32'h0, rd);
    endtask

    task automatic size_case(input logic [2:0] s);
        apb(1'b1, FDS_REG_CMD, {16'h0, FDS_CMD_DEPTH});
        apb(1'b1, FDS_REG_CMD, {29'h0, s});
        if (s <= 3'h4) begin
            sx = s;
            bx = 10'(11'h400 - (11'h400 >> s));
        end
        // idle queue: sixteen cycles is well past the decode latency
        repeat (16) @(posedge pclk);
        @(negedge pclk);
        chk("size_sel", {29'h0, sx}, {29'h0, fs});
        chk("begin", {22'h0, bx}, {22'h0, fb});
        chk("end", 32'h3ff, {22'h0, fe});
        probe(bx, 1'b1);
        probe(10'h3ff, 1'b1);
        if (bx != 10'h000) probe(bx - 10'h001, 1'b0);
        apb(1'b0, FDS_REG_STATUS, 32'h0);
        chk("status", {14'h0, 4'h0, bx, 1'b0, sx}, {14'h0, rd[17:0]});
    endtask

    task automatic size_all;
        apb(1'b1, FDS_REG_CTRL, {30'h0, FDS_SRC_RAM_PLAY});
        for (int s = 1; s < 5; s++) size_case(3'(s));
        apb(1'b1, FDS_REG_CTRL, {30'h0, FDS_SRC_TBL_SYNTH});
        @(negedge pclk);
        chk("src", {30'h0, FDS_SRC_TBL_SYNTH}, {30'h0, src});
        for (int s = 5; s < 8; s++) size_case(3'(s));
        size_case(3'h0);
    endtask

    task automatic synth_case(input logic [15:0] arg);
        hold <= 1'b1;
        base = n_done;
        apb(1'b1, FDS_REG_CMD, {16'h0, FDS_CMD_SYNTH});
        apb(1'b1, FDS_REG_CMD, {16'h0, arg});
        for (int i = 0; i < 50 && sv !== 1'b1; i++) @(negedge pclk);
        chk("synth_valid", 32'h1, {31'h0, sv});
        chk("end_wave", {28'h0, arg[15:12]}, {28'h0, ew});
        chk("start_wave", {28'h0, arg[11:8]}, {28'h0, sw});
        chk("flags", {27'h0, arg[4:0]}, {27'h0, fl});
        apb(1'b0, FDS_REG_SYNTH, 32'h0);
        chk("synth_reg", {16'h0, arg}, rd);
        hold <= 1'b0;
        repeat (8) @(negedge pclk);
        chk("taken", {24'h0, base + 8'h01}, {24'h0, n_done});
    endtask

    // engine stalls until writes back up, then drains everything
    task automatic fill_case;
        hold <= 1'b1;
        stalled = 1'b0;
        base = n_done;
        fork
            for (int i = 0; i < 12; i++) begin
                apb(1'b1, FDS_REG_CMD, {16'h0, FDS_CMD_SYNTH});
                apb(1'b1, FDS_REG_CMD, {16'h0, 4'(i), 12'h301});
            end
            begin
                for (int i = 0; i < 500 && !stalled; i++) @(posedge pclk);
                chk("queue_full", 32'h1, {31'h0, stalled});
                @(posedge pclk);
                hold <= 1'b0;
            end
        join
        for (int i = 0; i < 200 && n_done != base + 8'd12; i++) @(negedge pclk);
        chk("drained", {24'h0, base + 8'd12}, {24'h0, n_done});
        chk("last_word", 32'hb301, {16'h0, last_word});
    endtask

    task automatic err_case;
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped_err", 32'h1, {31'h0, err});
        chk("unmapped_data", 32'h0, rd);
    endtask

    // a frozen clock enable drops a write; sizing with drive on is applied and flagged
    task automatic misuse_case;
        ce <= 1'b0;
        apb(1'b1, FDS_REG_CTRL, 32'h4);
        @(negedge pclk);
        chk("frozen_drive", 32'h0, {31'h0, dv});
        @(posedge pclk);
        ce <= 1'b1;
        apb(1'b1, FDS_REG_CTRL, {29'h0, 1'b1, FDS_SRC_RAM_PLAY});
        @(negedge pclk);
        chk("drive", 32'h1, {31'h0, dv});
        apb(1'b1, FDS_REG_CMD, {16'h0, FDS_CMD_DEPTH});
        apb(1'b1, FDS_REG_CMD, 32'h3);
        apb(1'b1, FDS_REG_CMD, 32'h1);
        repeat (16) @(posedge pclk);
        apb(1'b0, FDS_REG_STATUS, 32'h0);
        chk("seq_unk", {14'h0, 2'h3, 2'h0, 10'h380, 1'b0, 3'h3}, {14'h0, rd[17:0]});
        apb(1'b1, FDS_REG_STATUS, 32'h30000);
        apb(1'b1, FDS_REG_CTRL, {30'h0, FDS_SRC_RAM_PLAY});
        size_case(3'h0);
    endtask

    task print_verdict;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        reset_case();
        size_all();
        synth_case(16'ha51f);
        synth_case(16'h5a0a);
        fill_case();
        err_case();
        misuse_case();
        print_verdict();
    end

    // the whole sequence needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        print_verdict();
    end
endmodule
